//--- ihp_pkg.sv
// Purpose: shared constants and types of the indirect host register port
// Assumes: 16-bit host bus, 32-bit indirect registers, four channels
// Notes: offsets are direct locations or indirect address fields
package ihp_pkg;

  // Direct locations selected by the 3-bit host address
  localparam logic [2:0] DIR_DATA_LO = 3'h0;
  localparam logic [2:0] DIR_DATA_HI = 3'h1;
  localparam logic [2:0] DIR_WADDR = 3'h2;
  localparam logic [2:0] DIR_RADDR = 3'h3;

  // Indirect address field positions
  localparam int CHAN_SEL_LSB = 12;
  localparam int IO_SEL_LSB = 8;

  // Global indirect addresses (low byte)
  localparam logic [7:0] GA_TOP_CTRL = 8'h00;
  localparam logic [7:0] GA_RNG_MAP = 8'h01;
  localparam logic [7:0] GA_TEST_CTRL = 8'h02;
  localparam logic [7:0] GA_TEST_STB = 8'h03;
  localparam logic [7:0] GA_SYNC_OUT = 8'h04;
  localparam logic [7:0] GA_SYNC_LOOP = 8'h05;
  localparam logic [7:0] GA_SOFT_RST = 8'h06;

  // I/O section offsets and storage index of the range control register
  localparam logic [7:0] IO_LAST_LOW = 8'h0a;
  localparam logic [7:0] IO_RNG_CTRL = 8'h10;
  localparam logic [3:0] IO_RNG_IDX = 4'hb;

  // Channel offset that clears latched saturation
  localparam logic [11:0] CH_SAT_CLR = 12'h01f;

  // Reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;

  // Stages of the pin synchroniser
  localparam int SYNC_STAGES = 3;

  // Host pins as seen by the core; strobes are active low
  typedef struct packed {
    logic ce_n;
    logic wr_n;
    logic rd_n;
    logic [2:0] addr;
    logic [15:0] data;
  } ihp_hbus_type;

  // Idle level of the host pins
  localparam ihp_hbus_type HBUS_IDLE = '{ce_n: 1'b1, wr_n: 1'b1,
    rd_n: 1'b1, addr: 3'h0, data: 16'h0000};

endpackage

//--- ihp_pin_sync.sv
// Purpose: three-stage synchroniser for the host pins
// Assumes: pins change without regard to the core clock
// Notes: callers compare the second and third stages only
`timescale 1ns/1ps
module ihp_pin_sync
  import ihp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire ihp_hbus_type pins_i,
  output ihp_hbus_type st2_o,
  output ihp_hbus_type st3_o
);
  ihp_hbus_type st1_q;
  ihp_hbus_type st2_q;
  ihp_hbus_type st3_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st1_q <= HBUS_IDLE;
      st2_q <= HBUS_IDLE;
      st3_q <= HBUS_IDLE;
    end else begin
      st1_q <= pins_i;
      st2_q <= st1_q;
      st3_q <= st2_q;
    end
  end

  assign st2_o = st2_q;
  assign st3_o = st3_q;
endmodule // ihp_pin_sync

//--- ihp_io_regs.sv
// Purpose: register storage of the four I/O control sections
// Assumes: index already mapped, reserved offsets never written
// Notes: read data leave a register one cycle after the index
`timescale 1ns/1ps
module ihp_io_regs
  import ihp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] we_i,
  input wire logic [3:0] widx_i,
  input wire logic [31:0] wdata_i,
  input wire logic [1:0] rsel_i,
  input wire logic [3:0] ridx_i,
  output logic [31:0] rdata_o
);
  // A net, since each section bank drives its own slice
  wire logic [3:0][31:0] sec_rd;

  // One bank per section so a broadcast writes several at once
  for (genvar s = 0; s < 4; s++) begin : g_sec
    logic [31:0] mem_q [16];
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        for (int i = 0; i < 16; i++) mem_q[i] <= WORD_RST;
      end else if (we_i[s]) begin
        mem_q[widx_i] <= wdata_i;
      end
    end
    assign sec_rd[s] = mem_q[ridx_i];
  end

  // Registered read port
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_o <= WORD_RST;
    else rdata_o <= sec_rd[rsel_i];
  end
endmodule // ihp_io_regs

//--- ihp_host_port.sv
// Purpose: direct/indirect host register port of a 4-channel converter
// Assumes: host pins are asynchronous; channel logic lives outside
// Notes: indirect writes launch one cycle after the address write
// Notes on behaviour
// - location 0 write loads holding bits 15:0
// - location 1 write loads holding bits 31:16
// - location 2 write sets address, launches write
// - location 3 write sets address, no write
// - location 0 read gives selected bits 15:0
// - location 1 read gives selected bits 31:16
// - location 2 read gives the status word
// - status: revision, latched saturation, zero odd bits
// - locations 4-7 read channel sequenced ports
// - global 0000h top control, readable back
// - 0002h test settings, 0003h test strobe
// - 0004h-0006h action strobes, reads give zero
// - global 0007h-00FFh reserved, nothing behind
// - select nibble picks target for read, write
// - bits 11:8 I/O, 15:12 channels, broadcast
// - I/O offset 00 format, 01-04 routing
// - I/O offsets 05 sync, 06-08 serial output
// - I/O offsets 09, 0A and 10 decoded
// - I/O offsets 0B-0F reserved
`timescale 1ns/1ps
module ihp_host_port
  import ihp_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h5a // Arbitrary revision value
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire ihp_hbus_type hbus_i,
  output logic [15:0] p_o,
  output logic p_oe_o,
  input wire logic [3:0] sat_i,
  input wire logic [3:0][15:0] seq_data_i,
  output logic [3:0] seq_rd_o,
  output logic [3:0] chan_we_o,
  output logic [11:0] chan_addr_o,
  output logic [31:0] chan_wdata_o,
  input wire logic [3:0][31:0] chan_rdata_i,
  output logic [31:0] top_ctrl_o,
  output logic [31:0] rng_map_o,
  output logic [31:0] test_ctrl_o,
  output logic test_strobe_o,
  output logic sync_output_pin_o,
  output logic first_sync_input_loop_o,
  output logic soft_reset_o
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  ihp_hbus_type st2;
  ihp_hbus_type st3;
  ihp_hbus_type pin_q;
  ihp_hbus_type cap_q;
  logic wr_on;
  logic wr_on_q;
  logic rd_on;
  logic rd_on_q;
  logic wr_ev;
  logic rd_end;
  logic [31:0] hold_q;
  logic [15:0] iaddr_q;
  logic wstb_q;
  logic [3:0] sat_q;
  logic [3:0] chan_sel;
  logic [3:0] io_sel;
  logic is_chan;
  logic is_io;
  logic [7:0] low;
  logic io_ok;
  logic [3:0] io_idx;
  logic [3:0] io_we;
  logic [1:0] io_rsel;
  logic [1:0] ch_rsel;
  logic [31:0] io_rd;
  logic [31:0] glob_rd;
  logic [31:0] rword;
  logic [15:0] status;
  logic [15:0] p_d;
  logic g_stb;
  logic [3:0] sat_clr;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  ihp_pin_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .pins_i(hbus_i),
    .st2_o(st2),
    .st3_o(st3)
  );

  // A pin bit changes only once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) pin_q <= HBUS_IDLE;
    else pin_q <= (st2 & st3) | (pin_q & (st2 | st3));
  end

  // Strobe levels and their trailing edges
  assign wr_on = !pin_q.ce_n && !pin_q.wr_n;
  assign rd_on = !pin_q.ce_n && !pin_q.rd_n;
  assign wr_ev = wr_on_q && !wr_on;
  assign rd_end = rd_on_q && !rd_on;

  // Address and data are captured while the write strobe is low
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_on_q <= 1'b0;
      rd_on_q <= 1'b0;
      cap_q <= HBUS_IDLE;
    end else begin
      wr_on_q <= wr_on;
      rd_on_q <= rd_on;
      if (wr_on) cap_q <= pin_q;
    end
  end

  // Direct writes: holding halves, shared indirect address
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= WORD_RST;
      iaddr_q <= HALF_RST;
      wstb_q <= 1'b0;
    end else begin
      wstb_q <= wr_ev && cap_q.addr == DIR_WADDR;
      if (wr_ev) begin
        case (cap_q.addr)
          DIR_DATA_LO: hold_q[15:0] <= cap_q.data;
          DIR_DATA_HI: hold_q[31:16] <= cap_q.data;
          DIR_WADDR: iaddr_q <= cap_q.data;
          DIR_RADDR: iaddr_q <= cap_q.data;
          default: ; // Locations 4-7 write nothing
        endcase
      end
    end
  end

  // Indirect address decode
  assign chan_sel = iaddr_q[CHAN_SEL_LSB +: 4];
  assign io_sel = iaddr_q[IO_SEL_LSB +: 4];
  assign is_chan = |chan_sel;
  assign is_io = !is_chan && (|io_sel);
  assign low = iaddr_q[7:0];
  assign io_ok = low <= IO_LAST_LOW || low == IO_RNG_CTRL;
  assign io_idx = (low == IO_RNG_CTRL) ? IO_RNG_IDX : low[3:0];
  assign io_we = (wstb_q && is_io && io_ok) ? io_sel : 4'h0;
  assign g_stb = wstb_q && !is_chan && !is_io && iaddr_q[11:8] == 4'h0;

  // Lowest set select bit picks the single read source
  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) r = 2'(i);
    end
    return r;
  endfunction
  assign io_rsel = first_set(io_sel);
  assign ch_rsel = first_set(chan_sel);

  ihp_io_regs u_io (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .we_i(io_we),
    .widx_i(io_idx),
    .wdata_i(hold_q),
    .rsel_i(io_rsel),
    .ridx_i(io_idx),
    .rdata_o(io_rd)
  );

  // Global writes and action strobes
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      top_ctrl_o <= WORD_RST;
      rng_map_o <= WORD_RST;
      test_ctrl_o <= WORD_RST;
      test_strobe_o <= 1'b0;
      sync_output_pin_o <= 1'b0;
      first_sync_input_loop_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      test_strobe_o <= g_stb && low == GA_TEST_STB;
      sync_output_pin_o <= g_stb && (low == GA_SYNC_OUT ||
        low == GA_SYNC_LOOP);
      first_sync_input_loop_o <= g_stb && low == GA_SYNC_LOOP;
      soft_reset_o <= g_stb && low == GA_SOFT_RST;
      if (g_stb && low == GA_TOP_CTRL) top_ctrl_o <= hold_q;
      if (g_stb && low == GA_RNG_MAP) rng_map_o <= hold_q;
      if (g_stb && low == GA_TEST_CTRL) test_ctrl_o <= hold_q;
    end
  end

  // Channel writes are passed out, broadcast by select bits
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      chan_we_o <= 4'h0;
      chan_addr_o <= 12'h000;
      chan_wdata_o <= WORD_RST;
    end else begin
      chan_we_o <= (wstb_q && is_chan) ? chan_sel : 4'h0;
      chan_addr_o <= iaddr_q[11:0];
      chan_wdata_o <= hold_q;
    end
  end

  // Saturation latches; a new event wins over a clear
  assign sat_clr = (wstb_q && is_chan && iaddr_q[11:0] == CH_SAT_CLR) ?
    chan_sel : 4'h0;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) sat_q <= 4'h0;
    else sat_q <= (sat_q & ~sat_clr) | sat_i;
  end

  // Read source selected by the indirect address
  always_comb begin
    glob_rd = WORD_RST;
    case (low)
      GA_TOP_CTRL: glob_rd = top_ctrl_o;
      GA_RNG_MAP: glob_rd = rng_map_o;
      GA_TEST_CTRL: glob_rd = test_ctrl_o;
      default: glob_rd = WORD_RST; // Strobes and reserved
    endcase
  end
  assign rword = is_chan ? chan_rdata_i[ch_rsel] :
    is_io ? (io_ok ? io_rd : WORD_RST) :
    (iaddr_q[11:8] == 4'h0 ? glob_rd : WORD_RST);

  // Status word: revision code over interleaved saturation bits
  assign status = {REV_CODE, 1'b0, sat_q[3], 1'b0, sat_q[2],
    1'b0, sat_q[1], 1'b0, sat_q[0]};

  // Direct read multiplexer
  always_comb begin
    p_d = HALF_RST;
    case (pin_q.addr)
      DIR_DATA_LO: p_d = rword[15:0];
      DIR_DATA_HI: p_d = rword[31:16];
      DIR_WADDR: p_d = status;
      DIR_RADDR: p_d = HALF_RST;
      default: p_d = seq_data_i[pin_q.addr[1:0]];
    endcase
  end

  // Bus drive while the read strobe is on, sequenced read advance at the end of a read
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      p_o <= HALF_RST;
      p_oe_o <= 1'b0;
      seq_rd_o <= 4'h0;
    end else begin
      p_o <= p_d;
      p_oe_o <= rd_on;
      seq_rd_o <= (rd_end && pin_q.addr[2]) ?
        4'(4'h1 << pin_q.addr[1:0]) : 4'h0;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  property p_hold_lo;
    wr_ev && cap_q.addr == DIR_DATA_LO |=>
      hold_q[15:0] == $past(cap_q.data) && $stable(hold_q[31:16]);
  endproperty
  a_hold_lo: assert property (p_hold_lo)
    else $error("low holding half not loaded");

  property p_hold_hi;
    wr_ev && cap_q.addr == DIR_DATA_HI |=>
      hold_q[31:16] == $past(cap_q.data) && $stable(hold_q[15:0]);
  endproperty
  a_hold_hi: assert property (p_hold_hi)
    else $error("high holding half not loaded");

  property p_wstb;
    wr_ev && cap_q.addr == DIR_WADDR |=>
      wstb_q && iaddr_q == $past(cap_q.data) ##1 !wstb_q;
  endproperty
  a_wstb: assert property (p_wstb)
    else $error("address write gave no single strobe");

  property p_raddr;
    wr_ev && cap_q.addr == DIR_RADDR |=>
      !wstb_q && iaddr_q == $past(cap_q.data);
  endproperty
  a_raddr: assert property (p_raddr)
    else $error("read address write misbehaved");

  property p_rsvd_wr;
    wr_ev && cap_q.addr[2] |=> $stable(hold_q) && $stable(iaddr_q)
      ##1 !wstb_q;
  endproperty
  a_rsvd_wr: assert property (p_rsvd_wr)
    else $error("reserved location write changed state");

  property p_rd_word;
    pin_q.addr == DIR_DATA_HI |=> p_o == $past(rword[31:16]);
  endproperty
  a_rd_word: assert property (p_rd_word)
    else $error("indirect read high half wrong");

  property p_status;
    pin_q.addr == DIR_WADDR |=>
      p_o[15:8] == REV_CODE && p_o[7] == 1'b0 && p_o[1] == 1'b0;
  endproperty
  a_status: assert property (p_status)
    else $error("status word fields wrong");

  property p_sat;
    sat_i[3] |=> sat_q[3] && status[6];
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturation not latched");

  property p_seq;
    rd_end && pin_q.addr == 3'h5 |=> seq_rd_o == 4'h2 ##1 seq_rd_o == 4'h0;
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequenced read advance wrong");

  property p_bcast;
    wstb_q && is_io && io_ok |-> io_we == iaddr_q[11:8];
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("I/O broadcast enables wrong");

  property p_glob_rsvd;
    g_stb && low > GA_SOFT_RST |=> !test_strobe_o && !soft_reset_o &&
      !sync_output_pin_o && $stable(top_ctrl_o);
  endproperty
  a_glob_rsvd: assert property (p_glob_rsvd)
    else $error("reserved global address acted");

  property p_io_rsvd;
    wstb_q && is_io && low > IO_LAST_LOW && low < IO_RNG_CTRL |->
      io_we == 4'h0;
  endproperty
  a_io_rsvd: assert property (p_io_rsvd)
    else $error("reserved I/O offset written");

endmodule // ihp_host_port

//--- ihp_host_model.sv
// Purpose: processor model driving the direct host port pins
// Assumes: strobes low and high well over three core cycles
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module ihp_host_model
  import ihp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [15:0] p_i,
  input wire logic p_oe_i,
  output ihp_hbus_type hbus_o
);
  // Pins idle until the first cycle
  initial hbus_o = HBUS_IDLE;

  // One bus cycle: address first, strobe for 8 edges, then idle
  task automatic cyc(input logic [2:0] a, input logic [15:0] d,
                     input logic wr, output logic [16:0] q);
    @(posedge clk_sys_i);
    hbus_o.addr <= a;
    hbus_o.data <= wr ? d : ~hbus_o.data;
    @(posedge clk_sys_i);
    hbus_o.ce_n <= 1'b0;
    hbus_o.wr_n <= ~wr;
    hbus_o.rd_n <= wr;
    repeat (8) @(posedge clk_sys_i);
    q = {p_oe_i, p_i};
    hbus_o.ce_n <= 1'b1;
    hbus_o.wr_n <= 1'b1;
    hbus_o.rd_n <= 1'b1;
    hbus_o.data <= ~hbus_o.data;
    // Idle gap covers the wait after an address write
    repeat (10) @(posedge clk_sys_i);
  endtask
endmodule // ihp_host_model

//--- indirect_host_register_port_bench.sv
// Purpose: self-checking bench of the indirect host register port
// Assumes: host model spaces every cycle well past sync delays
// Notes: pulse outputs are counted by a monitor process
`timescale 1ns/1ps
module indirect_host_register_port_bench;
  import ihp_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  ihp_hbus_type hbus;
  logic [15:0] p;
  logic p_oe;
  logic [3:0] sat = 4'h0;
  logic [3:0][15:0] seq_data = {16'h4d33, 16'h4c22, 16'h4b11, 16'h4a00};
  logic [3:0][31:0] chan_rdata = {32'h3333_c0c3, 32'h2222_b0b2,
    32'h1111_a0a1, 32'h0000_9090};
  logic [3:0] seq_rd, chan_we, we_seen;
  wire logic [3:0] pulses;
  logic [11:0] chan_addr, addr_seen;
  logic [31:0] chan_wdata, wdata_seen, top, rmap, tctl;
  logic [16:0] q;
  int pcnt[4];
  int scnt[4];
  int failures = 0;
  int cmp_count = 0;

  // Core clock, 8 ns period
  always #4 clk_sys_i = ~clk_sys_i;

  ihp_host_model host (.clk_sys_i(clk_sys_i), .p_i(p), .p_oe_i(p_oe),
    .hbus_o(hbus));

  ihp_host_port #(.REV_CODE(REV)) uut (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .hbus_i(hbus), .p_o(p), .p_oe_o(p_oe),
    .sat_i(sat), .seq_data_i(seq_data), .seq_rd_o(seq_rd),
    .chan_we_o(chan_we), .chan_addr_o(chan_addr),
    .chan_wdata_o(chan_wdata), .chan_rdata_i(chan_rdata),
    .top_ctrl_o(top), .rng_map_o(rmap), .test_ctrl_o(tctl),
    .test_strobe_o(pulses[0]), .sync_output_pin_o(pulses[1]),
    .first_sync_input_loop_o(pulses[2]), .soft_reset_o(pulses[3]));

  // Count pulses and keep the last channel write
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < 4; i++) begin
      pcnt[i] += int'(pulses[i] === 1'b1);
      scnt[i] += int'(seq_rd[i] === 1'b1);
    end
    if (chan_we !== 4'h0) begin
      we_seen <= chan_we;
      addr_seen <= chan_addr;
      wdata_seen <= chan_wdata;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    host.cyc(a, d, 1'b1, q);
  endtask

  task automatic rd(input logic [2:0] a);
    host.cyc(a, 16'h0000, 1'b0, q);
  endtask

  // Indirect write: both halves, then the address that launches it
  task automatic iwr(input logic [15:0] ia, input logic [31:0] v);
    wr(DIR_DATA_LO, v[15:0]);
    wr(DIR_DATA_HI, v[31:16]);
    wr(DIR_WADDR, ia);
  endtask

  // Indirect read of both halves; upper check also needs bus enable
  task automatic ird(input logic [15:0] ia, input logic [31:0] exp);
    wr(DIR_RADDR, ia);
    rd(DIR_DATA_LO);
    chk({16'h0000, q[15:0]}, {16'h0000, exp[15:0]});
    rd(DIR_DATA_HI);
    chk({15'h0000, q}, {16'h0001, exp[31:16]});
  endtask

  task automatic t_global();
    iwr(16'h0000, 32'ha5c3_1e0f);
    chk(top, 32'ha5c3_1e0f);
    ird(16'h0000, 32'ha5c3_1e0f);
    iwr(16'h0001, 32'h0123_4567);
    chk(rmap, 32'h0123_4567);
    iwr(16'h0002, 32'h89ab_cdef);
    chk(tctl, 32'h89ab_cdef);
    ird(16'h0002, 32'h89ab_cdef);
  endtask

  // Strobe addresses 3..6 and the pulse outputs each must raise
  task automatic t_strobes();
    logic [3:0] m[4] = '{4'h1, 4'h2, 4'h6, 4'h8};
    int b[4];
    for (int g = 0; g < 4; g++) begin
      b = pcnt;
      iwr(16'(g + 3), 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
        chk_n(pcnt[i] - b[i], int'(m[g][i]));
      end
      ird(16'(g + 3), 32'h0000_0000);
    end
  endtask

  task automatic t_reserved();
    int b[4];
    b = pcnt;
    iwr(16'h0007, 32'hffff_ffff);
    iwr(16'h00ff, 32'hffff_ffff);
    chk(top ^ rmap ^ tctl, 32'h2d4b_9687);
    chk_n(pcnt.sum() - b.sum(), 0);
    ird(16'h00ff, 32'h0000_0000);
    wr(DIR_DATA_LO, 16'h1111);
    wr(DIR_DATA_HI, 16'h2222);
    wr(DIR_RADDR, 16'h0000);
    chk(top, 32'ha5c3_1e0f);
    for (int a = 4; a < 8; a++) begin
      wr(3'(a), 16'hdead);
    end
    wr(DIR_WADDR, 16'h0001);
    chk(rmap, 32'h2222_1111);
  endtask

  // Broadcast to channels 0 and 2, then read each channel alone
  task automatic t_chan();
    iwr(16'h5020, 32'hbeef_0042);
    chk({28'h0, we_seen}, 32'h5);
    chk({20'h0, addr_seen}, 32'h20);
    chk(wdata_seen, 32'hbeef_0042);
    for (int c = 0; c < 4; c++) begin
      ird(16'(16'h1000 << c), chan_rdata[c]);
    end
  endtask

  task automatic t_io();
    logic [7:0] o[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h10};
    for (int i = 0; i < 12; i++) begin
      iwr({8'h0c, o[i]}, {16'hc0de, 8'(i), o[i]});
    end
    iwr(16'h0c0b, 32'hffff_ffff);
    for (int i = 0; i < 12; i++) begin
      ird({8'h04, o[i]}, {16'hc0de, 8'(i), o[i]});
    end
    ird(16'h0810, 32'hc0de_0b10);
    ird(16'h0100, 32'h0000_0000);
    ird(16'h040b, 32'h0000_0000);
  endtask

  task automatic t_status();
    @(posedge clk_sys_i);
    sat <= 4'b1011;
    @(posedge clk_sys_i);
    sat <= 4'h0;
    rd(DIR_WADDR);
    chk({15'h0, q}, {16'h0001, REV, 8'h45});
    iwr(16'h901f, 32'h0000_0000);
    rd(DIR_WADDR);
    chk({15'h0, q}, {16'h0001, REV, 8'h04});
  endtask

  task automatic t_seq();
    int b[4];
    for (int c = 0; c < 4; c++) begin
      b = scnt;
      rd(3'(c + 4));
      chk({15'h0, q}, {16'h1, seq_data[c]});
      chk_n(scnt[c] - b[c], 1);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    t_global();
    t_strobes();
    t_reserved();
    t_chan();
    t_io();
    t_status();
    t_seq();
    end_of_test();
  end

  // Watchdog, several times the expected run length
  initial begin
    #300us;
    failures++;
    end_of_test();
  end
endmodule // indirect_host_register_port_bench
